//--- pkg/stf_pkg.sv
`default_nettype none
package stf_pkg;

    // ------------
    // Parameter indices
    // ------------
    localparam logic [7:0] STF_IDX_SWITCH_SELECT = 8'h2a;
    localparam logic [7:0] STF_IDX_FWD_ALT = 8'h2b;
    localparam logic [7:0] STF_IDX_REV_ALT = 8'h2c;
    localparam logic [7:0] STF_IDX_FE_TIME = 8'h45;
    localparam logic [7:0] STF_IDX_INP_TIME = 8'h47;
    localparam logic [7:0] STF_IDX_SPD_TIME = 8'h49;
    localparam logic [7:0] STF_IDX_MAX_TQ_CFG = 8'h4e;

    // ------------
    // Field layout and reset values
    // ------------
    localparam int STF_DIGIT0_LSB = 0;
    localparam int STF_DIGIT1_LSB = 4;
    localparam logic [3:0] STF_DIGIT_ENABLED = 4'h1;
    localparam logic [3:0] STF_SWITCH_SEL_RST = 4'h0;
    localparam logic [3:0] STF_MAX_TQ_SEL_RST = 4'h1;
    localparam logic [31:0] STF_MAX_TQ_CFG_RST = 32'h00000010;
    // Torque in units of 0.1 percent of rated torque
    localparam logic [15:0] STF_TORQUE_MAX_SETTING = 16'h2710; // 1000.0 %
    localparam logic [15:0] STF_ALT_LIMIT_RST = 16'h2710;
    localparam logic [15:0] STF_FILTER_TIME_RST = 16'h0000;

    // Control word and status word bits
    localparam int STF_CW_POS_SWITCH_BIT = 11;
    localparam int STF_CW_NEG_SWITCH_BIT = 12;
    localparam int STF_SW_TARGET_REACHED_BIT = 10;
    localparam int STF_SW_FOLLOWING_ERR_BIT = 13;

    // Level values with special meaning
    localparam logic [31:0] STF_FE_LEVEL_DISABLED = 32'h0fffffff;
    localparam logic [31:0] STF_INP_RANGE_ALWAYS = 32'hffffffff;

    // ------------
    // Timing
    // ------------
    localparam int STF_CLK_PERIOD_NS = 20;
    localparam int STF_MS_NS = 1000000;
    localparam int STF_MS_CYCLES = STF_MS_NS / STF_CLK_PERIOD_NS;

    // Operating modes
    typedef enum logic [3:0] {
        STF_MODE_CSP,
        STF_MODE_CSV,
        STF_MODE_CST,
        STF_MODE_PP,
        STF_MODE_PV,
        STF_MODE_TQ,
        STF_MODE_HM,
        STF_MODE_PT,
        STF_MODE_JG
    } stf_mode_e;

endpackage
`default_nettype wire

//--- hdl/stf_filter_timer.sv
`timescale 1ns/100ps
`default_nettype none
module stf_filter_timer (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Timing
    input wire logic ms_tick,
    input wire logic [15:0] filter_ms,
    // Condition
    input wire logic cond,
    input wire logic force_on,
    // Result
    output logic flag_q
);
    import stf_pkg::*;

    typedef struct packed {
        logic [15:0] count;
        logic flag;
    } stf_timer_s;

    stf_timer_s st_q, st_d;

    always_comb begin
        st_d = st_q;
        if (force_on) begin
            st_d.count = 16'h0000;
            st_d.flag = 1'b1;
        end else if (!cond) begin
            // Restart and drop the flag at once
            st_d.count = 16'h0000; // [R20]
            st_d.flag = 1'b0; // [R20]
        end else begin
            if (ms_tick && st_q.count < filter_ms) begin
                st_d.count = st_q.count + 16'h0001;
            end
            st_d.flag = (st_q.count >= filter_ms);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign flag_q = st_q.flag;

endmodule // stf_filter_timer
`default_nettype wire

//--- hdl/stf_torque_limit_sel.sv
`timescale 1ns/100ps
`default_nettype none
module stf_torque_limit_sel (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Selection
    input wire logic use_fwd_alt,
    input wire logic use_rev_alt,
    // Limit sources, 0.1 % units
    input wire logic [15:0] fwd_primary,
    input wire logic [15:0] rev_primary,
    input wire logic [15:0] fwd_alt,
    input wire logic [15:0] rev_alt,
    input wire logic [15:0] ceiling,
    // Applied limits
    output logic [15:0] fwd_applied_q,
    output logic [15:0] rev_applied_q
);
    import stf_pkg::*;

    typedef struct packed {
        logic [15:0] fwd;
        logic [15:0] rev;
    } stf_lim_s;

    stf_lim_s st_q, st_d;

    function automatic logic [15:0] umin(input logic [15:0] a,
                                         input logic [15:0] b);
        umin = (a < b) ? a : b;
    endfunction

    always_comb begin
        st_d = st_q;
        // A zero limit passes through as zero, giving no torque [R6]
        st_d.fwd = umin(use_fwd_alt ? fwd_alt : fwd_primary, ceiling); // [R2] [R7]
        st_d.rev = umin(use_rev_alt ? rev_alt : rev_primary, ceiling); // [R3] [R7]
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign fwd_applied_q = st_q.fwd;
    assign rev_applied_q = st_q.rev;

endmodule // stf_torque_limit_sel
`default_nettype wire

//--- hdl/stf_servo_limit_status.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// R1: Switch-select field gates control-word bits 11/12; reset 0 means ignored.
// R2: Enabled and bit 11 set applies alternate forward limit, else primary.
// R3: Enabled and bit 12 set applies alternate reverse limit, else primary.
// R4: Alternate forward limit spans 0.0-1000.0 percent, resets to 1000.0.
// R5: Alternate reverse limit spans 0.0-1000.0 percent, resets to 1000.0.
// R6: A zero applied limit yields no torque in that direction.
// R7: Limits above motor maximum torque are clamped to that maximum.
// R8: Direction and polarity settings swap which alternate object maps where.
// R9: Status bit 13 sets after droop stays at/above level for filter time.
// R10: Following-error check only in csp, pp, point table and jog modes.
// R11: All-ones following-error level disables the following-error output; the code disables it at level 0fffffff instead.
// R12: Status bit 10 sets after position error stays in range for filter time.
// R13: Maximum in-position range holds target reached permanently on.
// R14: In-position check only in pp, point table and jog modes.
// R15: Status bit 10 sets after speed error stays in range for filter time.
// R16: Speed-reached check only in profile velocity mode.
// R17: Maximum torque limit 1 enable field, reset value 1.
// R18: Cyclic controller values overwrite filter-time parameters.
// R19: With limit 1 off, its value is ignored; object reads motor maximum.
// R20: Each filter timer restarts and clears its bit when condition drops.
module stf_servo_limit_status #(
    parameter int MS_TICK_CYCLES = stf_pkg::STF_MS_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Parameter write port
    input wire logic prm_wr_en,
    input wire logic [7:0] prm_wr_idx,
    input wire logic [31:0] prm_wr_data,
    // Parameter read port
    input wire logic [7:0] prm_rd_idx,
    output logic [31:0] prm_rd_data_q,
    // Cyclic writes of mapped filter-time objects
    input wire logic cyc_fe_time_vld,
    input wire logic [15:0] cyc_fe_time,
    input wire logic cyc_inp_time_vld,
    input wire logic [15:0] cyc_inp_time,
    input wire logic cyc_spd_time_vld,
    input wire logic [15:0] cyc_spd_time,
    // Control
    input wire logic [15:0] control_word,
    input wire stf_pkg::stf_mode_e op_mode,
    // Torque sources, 0.1 % units
    input wire logic [15:0] forward_limit_primary,
    input wire logic [15:0] reverse_limit_primary,
    input wire logic [15:0] motor_max_torque,
    input wire logic [15:0] max_torque_one_value,
    input wire logic travel_direction_select,
    input wire logic torque_polarity_reflect,
    // Motion measurements and levels
    input wire logic [31:0] droop_pulses,
    input wire logic [31:0] following_err_level,
    input wire logic [31:0] position_error,
    input wire logic [31:0] in_position_range,
    input wire logic [31:0] speed_error,
    input wire logic [31:0] speed_reached_range,
    // Results
    output logic [15:0] fwd_torque_limit_q,
    output logic [15:0] rev_torque_limit_q,
    output logic [15:0] max_torque_obj_q,
    output logic [15:0] status_word_q
);
    import stf_pkg::*;

    // ------------
    // State
    // ------------
    typedef struct packed {
        logic [3:0] switch_select;
        logic [15:0] fwd_alt;
        logic [15:0] rev_alt;
        logic [15:0] fe_time;
        logic [15:0] inp_time;
        logic [15:0] spd_time;
        logic [3:0] max_tq_digit0;
        logic [3:0] max_tq_select;
        logic [31:0] rd_data;
        logic [15:0] max_tq_obj;
        logic [15:0] status_word;
        logic [31:0] tick_cnt;
        logic ms_tick;
    } stf_state_s;

    stf_state_s st_q, st_d;

    // ------------
    // Helpers
    // ------------
    function automatic logic [15:0] clamp_setting(input logic [31:0] v);
        if (v > {16'h0000, STF_TORQUE_MAX_SETTING}) begin
            clamp_setting = STF_TORQUE_MAX_SETTING;
        end else begin
            clamp_setting = v[15:0];
        end
    endfunction

    function automatic logic in_position_mode(input stf_mode_e m);
        in_position_mode = (m == STF_MODE_PP) || (m == STF_MODE_PT) ||
                           (m == STF_MODE_JG);
    endfunction

    localparam logic [31:0] TICK_LAST = 32'(MS_TICK_CYCLES - 1);

    // ------------
    // Combinational decode
    // ------------
    logic switch_en;
    logic max_tq_en;
    logic obj_swap;
    logic [15:0] fwd_alt_mapped;
    logic [15:0] rev_alt_mapped;
    logic [15:0] ceiling;
    logic fe_cond;
    logic inp_cond;
    logic inp_always;
    logic spd_cond;
    logic fe_flag;
    logic inp_flag;
    logic spd_flag;
    logic [15:0] fwd_applied;
    logic [15:0] rev_applied;

    assign switch_en = (st_q.switch_select == STF_DIGIT_ENABLED); // [R1]
    assign max_tq_en = (st_q.max_tq_select == STF_DIGIT_ENABLED); // [R17]

    // Reversed travel with polarity reflection swaps the objects
    assign obj_swap = travel_direction_select & torque_polarity_reflect;
    assign fwd_alt_mapped = obj_swap ? st_q.rev_alt : st_q.fwd_alt; // [R8]
    assign rev_alt_mapped = obj_swap ? st_q.fwd_alt : st_q.rev_alt; // [R8]

    // Limit 1 only narrows the ceiling while enabled
    always_comb begin
        ceiling = motor_max_torque; // [R7]
        if (max_tq_en && max_torque_one_value < motor_max_torque) begin
            ceiling = max_torque_one_value; // [R19]
        end
    end

    // Qualifying conditions for the three filters
    always_comb begin
        fe_cond = 1'b0;
        if ((op_mode == STF_MODE_CSP) || in_position_mode(op_mode)) begin // [R10]
            fe_cond = (following_err_level != STF_FE_LEVEL_DISABLED) && // [R11]
                      (droop_pulses >= following_err_level); // [R9]
        end
    end

    assign inp_always = in_position_mode(op_mode) &&
                        (in_position_range == STF_INP_RANGE_ALWAYS); // [R13]
    assign inp_cond = in_position_mode(op_mode) && // [R14]
                      (position_error <= in_position_range); // [R12]
    assign spd_cond = (op_mode == STF_MODE_PV) && // [R16]
                      (speed_error <= speed_reached_range); // [R15]

    // ------------
    // Sub-blocks
    // ------------
    stf_torque_limit_sel u_limit_sel (
        .core_clk(core_clk),
        .rst(rst),
        .use_fwd_alt(switch_en && control_word[STF_CW_POS_SWITCH_BIT]), // [R2]
        .use_rev_alt(switch_en && control_word[STF_CW_NEG_SWITCH_BIT]), // [R3]
        .fwd_primary(forward_limit_primary),
        .rev_primary(reverse_limit_primary),
        .fwd_alt(fwd_alt_mapped),
        .rev_alt(rev_alt_mapped),
        .ceiling(ceiling),
        .fwd_applied_q(fwd_applied),
        .rev_applied_q(rev_applied)
    );

    stf_filter_timer u_fe_timer (
        .core_clk(core_clk),
        .rst(rst),
        .ms_tick(st_q.ms_tick),
        .filter_ms(st_q.fe_time), // [R9]
        .cond(fe_cond),
        .force_on(1'b0),
        .flag_q(fe_flag)
    );

    stf_filter_timer u_inp_timer (
        .core_clk(core_clk),
        .rst(rst),
        .ms_tick(st_q.ms_tick),
        .filter_ms(st_q.inp_time), // [R12]
        .cond(inp_cond),
        .force_on(inp_always), // [R13]
        .flag_q(inp_flag)
    );

    stf_filter_timer u_spd_timer (
        .core_clk(core_clk),
        .rst(rst),
        .ms_tick(st_q.ms_tick),
        .filter_ms(st_q.spd_time), // [R15]
        .cond(spd_cond),
        .force_on(1'b0),
        .flag_q(spd_flag)
    );

    // ------------
    // Next-state logic
    // ------------
    always_comb begin
        st_d = st_q;

        // Millisecond time base
        st_d.ms_tick = 1'b0;
        if (st_q.tick_cnt >= TICK_LAST) begin
            st_d.tick_cnt = 32'h00000000;
            st_d.ms_tick = 1'b1;
        end else begin
            st_d.tick_cnt = st_q.tick_cnt + 32'h00000001;
        end

        // Parameter writes from the engineering path
        if (prm_wr_en) begin
            case (prm_wr_idx)
                STF_IDX_SWITCH_SELECT: begin
                    st_d.switch_select = prm_wr_data[STF_DIGIT0_LSB +: 4]; // [R1]
                end
                STF_IDX_FWD_ALT: begin
                    st_d.fwd_alt = clamp_setting(prm_wr_data); // [R4]
                end
                STF_IDX_REV_ALT: begin
                    st_d.rev_alt = clamp_setting(prm_wr_data); // [R5]
                end
                STF_IDX_FE_TIME: begin
                    st_d.fe_time = prm_wr_data[15:0];
                end
                STF_IDX_INP_TIME: begin
                    st_d.inp_time = prm_wr_data[15:0];
                end
                STF_IDX_SPD_TIME: begin
                    st_d.spd_time = prm_wr_data[15:0];
                end
                STF_IDX_MAX_TQ_CFG: begin
                    st_d.max_tq_digit0 = prm_wr_data[STF_DIGIT0_LSB +: 4];
                    st_d.max_tq_select = prm_wr_data[STF_DIGIT1_LSB +: 4]; // [R17]
                end
                default: begin
                end
            endcase
        end

        // Cyclic values come last so they win over a same-cycle write
        if (cyc_fe_time_vld) begin
            st_d.fe_time = cyc_fe_time; // [R18]
        end
        if (cyc_inp_time_vld) begin
            st_d.inp_time = cyc_inp_time; // [R18]
        end
        if (cyc_spd_time_vld) begin
            st_d.spd_time = cyc_spd_time; // [R18]
        end

        // Read-back of stored parameters, unmapped indices read zero
        case (prm_rd_idx)
            STF_IDX_SWITCH_SELECT: begin
                st_d.rd_data = {28'h0000000, st_q.switch_select};
            end
            STF_IDX_FWD_ALT: begin
                st_d.rd_data = {16'h0000, st_q.fwd_alt};
            end
            STF_IDX_REV_ALT: begin
                st_d.rd_data = {16'h0000, st_q.rev_alt};
            end
            STF_IDX_FE_TIME: begin
                st_d.rd_data = {16'h0000, st_q.fe_time};
            end
            STF_IDX_INP_TIME: begin
                st_d.rd_data = {16'h0000, st_q.inp_time};
            end
            STF_IDX_SPD_TIME: begin
                st_d.rd_data = {16'h0000, st_q.spd_time};
            end
            STF_IDX_MAX_TQ_CFG: begin
                st_d.rd_data = {24'h000000, st_q.max_tq_select,
                                st_q.max_tq_digit0};
            end
            default: begin
                st_d.rd_data = 32'h00000000;
            end
        endcase

        // Maximum torque object view
        st_d.max_tq_obj = max_tq_en ? max_torque_one_value
                                    : motor_max_torque; // [R19]

        // Status word; the target bit means position or velocity by mode
        st_d.status_word = 16'h0000;
        st_d.status_word[STF_SW_TARGET_REACHED_BIT] = inp_flag | spd_flag; // [R12] [R15]
        st_d.status_word[STF_SW_FOLLOWING_ERR_BIT] = fe_flag; // [R9]
    end

    // ------------
    // State register
    // ------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q <= '0;
            st_q.switch_select <= STF_SWITCH_SEL_RST; // [R1]
            st_q.fwd_alt <= STF_ALT_LIMIT_RST; // [R4]
            st_q.rev_alt <= STF_ALT_LIMIT_RST; // [R5]
            st_q.fe_time <= STF_FILTER_TIME_RST;
            st_q.inp_time <= STF_FILTER_TIME_RST;
            st_q.spd_time <= STF_FILTER_TIME_RST;
            st_q.max_tq_digit0 <= STF_MAX_TQ_CFG_RST[3:0];
            st_q.max_tq_select <= STF_MAX_TQ_SEL_RST; // [R17]
        end else begin
            st_q <= st_d;
        end
    end

    // ------------
    // Outputs
    // ------------
    assign prm_rd_data_q = st_q.rd_data;
    assign fwd_torque_limit_q = fwd_applied;
    assign rev_torque_limit_q = rev_applied;
    assign max_torque_obj_q = st_q.max_tq_obj;
    assign status_word_q = st_q.status_word;

endmodule // stf_servo_limit_status
`default_nettype wire

//--- tb/stf_servo_limit_status_sva.sv
`timescale 1ns/100ps
`default_nettype none
module stf_servo_limit_status_chk (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Watched inputs
    input wire logic [15:0] control_word,
    input wire stf_pkg::stf_mode_e op_mode,
    input wire logic [15:0] forward_limit_primary,
    input wire logic [15:0] reverse_limit_primary,
    input wire logic [15:0] motor_max_torque,
    input wire logic [15:0] max_torque_one_value,
    input wire logic [31:0] droop_pulses,
    input wire logic [31:0] following_err_level,
    // Watched outputs
    input wire logic [15:0] fwd_torque_limit_q,
    input wire logic [15:0] rev_torque_limit_q,
    input wire logic [15:0] max_torque_obj_q,
    input wire logic [15:0] status_word_q
);
    import stf_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Following-error and target-reached checks outside their modes, droop below level
    sequence s_fe_mode_off;
        !(op_mode inside {STF_MODE_CSP, STF_MODE_PP, STF_MODE_PT,
            STF_MODE_JG});
    endsequence
    sequence s_tgt_mode_off;
        !(op_mode inside {STF_MODE_PP, STF_MODE_PT, STF_MODE_JG,
            STF_MODE_PV});
    endsequence
    sequence s_fe_below;
        droop_pulses < following_err_level;
    endsequence

    AST_FWD_PRIMARY: assert property ((!control_word[11])[*2] |->
        fwd_torque_limit_q <= $past(forward_limit_primary))
        else $error("fwd limit above primary");
    AST_REV_PRIMARY: assert property ((!control_word[12])[*2] |->
        rev_torque_limit_q <= $past(reverse_limit_primary))
        else $error("rev limit above primary");
    AST_FWD_CEILING: assert property (
        fwd_torque_limit_q <= $past(motor_max_torque))
        else $error("forward limit above motor maximum");
    AST_REV_CEILING: assert property (
        rev_torque_limit_q <= $past(motor_max_torque))
        else $error("reverse limit above motor maximum");
    AST_MAX_OBJ: assert property (!$past(rst) |->
        max_torque_obj_q == $past(motor_max_torque) ||
        max_torque_obj_q == $past(max_torque_one_value))
        else $error("max torque object from neither source");
    AST_STATUS_UNUSED: assert property (
        (status_word_q & ~16'h2400) == 16'h0000)
        else $error("unused status bit set");
    AST_FE_DISABLED: assert property (
        (following_err_level == STF_FE_LEVEL_DISABLED)[*3] |->
        !status_word_q[13])
        else $error("fe bit with level off");
    AST_FE_MODE: assert property (s_fe_mode_off[*3] |->
        !status_word_q[13])
        else $error("following error set outside its modes");
    AST_FE_CLEAR: assert property (s_fe_below[*3] |->
        !status_word_q[13])
        else $error("following error kept after droop fell");
    AST_TGT_MODE: assert property (s_tgt_mode_off[*3] |->
        !status_word_q[10])
        else $error("target reached set outside its modes");
endmodule // stf_servo_limit_status_chk

bind stf_servo_limit_status stf_servo_limit_status_chk u_chk (.*);
`default_nettype wire

//--- tb/stf_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module stf_ctrl_model (
    // Clock
    input wire logic core_clk,
    // Cyclic filter-time objects
    output logic cyc_fe_time_vld,
    output logic [15:0] cyc_fe_time,
    output logic cyc_inp_time_vld,
    output logic [15:0] cyc_inp_time,
    output logic cyc_spd_time_vld,
    output logic [15:0] cyc_spd_time,
    // Control word
    output logic [15:0] control_word
);
    import stf_pkg::*;
    initial begin
        {cyc_fe_time_vld, cyc_inp_time_vld, cyc_spd_time_vld} = 3'h0;
        {cyc_fe_time, cyc_inp_time, cyc_spd_time} = {3{16'h5a5a}};
        control_word = 16'h0000;
    end
    // One-cycle cyclic write: 0 following, 1 in-position, 2 speed
    task automatic send_time(input int sel, input logic [15:0] ms);
        @(posedge core_clk);
        #1;
        cyc_fe_time_vld = (sel == 0);
        cyc_inp_time_vld = (sel == 1);
        cyc_spd_time_vld = (sel == 2);
        {cyc_fe_time, cyc_inp_time, cyc_spd_time} = {3{ms}};
        @(posedge core_clk);
        #1;
        {cyc_fe_time_vld, cyc_inp_time_vld, cyc_spd_time_vld} = 3'h0;
        {cyc_fe_time, cyc_inp_time, cyc_spd_time} = {3{~ms}};
    endtask
    task automatic set_switch(input logic pos, input logic neg);
        @(posedge core_clk);
        #1;
        control_word[STF_CW_POS_SWITCH_BIT] = pos;
        control_word[STF_CW_NEG_SWITCH_BIT] = neg;
    endtask
endmodule // stf_ctrl_model
`default_nettype wire

//--- tb/stf_servo_limit_status_test.sv
`timescale 1ns/100ps
`default_nettype none
module stf_servo_limit_status_test;
    import stf_pkg::*;
    typedef struct packed {
        logic sel; logic p; logic n; logic [15:0] f; logic [15:0] r;
    } stf_row_s;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic prm_wr_en = 1'b0;
    logic [7:0] prm_wr_idx = 8'h00;
    logic [31:0] prm_wr_data = 32'h0;
    logic [7:0] prm_rd_idx = 8'h00;
    stf_mode_e op_mode = STF_MODE_TQ;
    logic [15:0] forward_limit_primary = 16'h0bb8;
    logic [15:0] reverse_limit_primary = 16'h0fa0;
    logic [15:0] motor_max_torque = 16'h1f40;
    logic [15:0] max_torque_one_value = 16'h2328;
    logic travel_direction_select = 1'b0;
    logic torque_polarity_reflect = 1'b0;
    logic [31:0] droop_pulses = 32'h0, following_err_level = 32'h64;
    logic [31:0] position_error = 32'h5, in_position_range = 32'ha;
    logic [31:0] speed_error = 32'h3, speed_reached_range = 32'h5;
    logic cyc_fe_time_vld, cyc_inp_time_vld, cyc_spd_time_vld;
    logic [15:0] cyc_fe_time, cyc_inp_time, cyc_spd_time, control_word;
    logic [31:0] prm_rd_data_q;
    logic [15:0] fwd_torque_limit_q, rev_torque_limit_q;
    logic [15:0] max_torque_obj_q, status_word_q;
    int mismatches = 0;
    int compares = 0;
    logic [7:0] ridx [8] = '{8'h2a, 8'h2b, 8'h2c, 8'h45, 8'h47, 8'h49,
        8'h4e, 8'h00};
    logic [31:0] rexp [8] = '{32'h0, 32'h2710, 32'h2710, 32'h0, 32'h0,
        32'h0, 32'h10, 32'h0};
    stf_row_s rows [5] = '{'{1'b0, 1'b1, 1'b1, 16'h0bb8, 16'h0fa0},
        '{1'b1, 1'b0, 1'b0, 16'h0bb8, 16'h0fa0},
        '{1'b1, 1'b1, 1'b0, 16'h01f4, 16'h0fa0},
        '{1'b1, 1'b0, 1'b1, 16'h0bb8, 16'h0000},
        '{1'b1, 1'b1, 1'b1, 16'h01f4, 16'h0000}};

    stf_servo_limit_status #(.MS_TICK_CYCLES(5)) uut (.*);
    stf_ctrl_model ctrl (.*);

    always #10 core_clk = ~core_clk;

    // ------------
    // Tasks
    // ------------
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] got,
        input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        prm_wr_en = 1'b1;
        prm_wr_idx = idx;
        prm_wr_data = d;
        tick(1);
        prm_wr_en = 1'b0;
        prm_wr_data = ~d;
        tick(1);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] e);
        prm_rd_idx = idx;
        tick(1);
        chk("read", prm_rd_data_q, e);
    endtask
    task automatic wait_word(input logic [15:0] e, input int lim);
        int n;
        n = 0;
        while (status_word_q !== e && n < lim) begin
            tick(1);
            n++;
        end
        chk("status wait", {16'h0, status_word_q}, {16'h0, e});
        if (status_word_q !== e) begin
            stop_test();
        end
    endtask

    // ------------
    // Sequence
    // ------------
    initial begin
        int i;
        logic [15:0] e;
        tick(6);
        rst = 1'b0;
        for (i = 0; i < 8; i++) begin
            rd_chk(ridx[i], rexp[i]);
        end
        chk("max obj", max_torque_obj_q, 32'h2328);
        $display("test reset values done");
        wr(STF_IDX_FWD_ALT, 32'h1f4);
        wr(STF_IDX_REV_ALT, 32'h0);
        for (i = 0; i < 5; i++) begin
            wr(STF_IDX_SWITCH_SELECT, {31'h0, rows[i].sel});
            ctrl.set_switch(rows[i].p, rows[i].n);
            tick(2);
            chk("fwd", fwd_torque_limit_q, rows[i].f);
            chk("rev", rev_torque_limit_q, rows[i].r);
        end
        $display("test limit select done");
        motor_max_torque = 16'h1770;
        wr(STF_IDX_FWD_ALT, 32'h2ee0);
        rd_chk(STF_IDX_FWD_ALT, 32'h2710);
        chk("fwd clamp", fwd_torque_limit_q, 32'h1770);
        max_torque_one_value = 16'h07d0;
        wr(STF_IDX_MAX_TQ_CFG, 32'h0);
        tick(1);
        chk("obj off", max_torque_obj_q, 32'h1770);
        chk("fwd off", fwd_torque_limit_q, 32'h1770);
        wr(STF_IDX_MAX_TQ_CFG, 32'h10);
        tick(1);
        chk("obj on", max_torque_obj_q, 32'h07d0);
        chk("fwd on", fwd_torque_limit_q, 32'h07d0);
        motor_max_torque = 16'h1f40;
        max_torque_one_value = 16'h2328;
        wr(STF_IDX_FWD_ALT, 32'h1f4);
        wr(STF_IDX_REV_ALT, 32'h2bc);
        travel_direction_select = 1'b1;
        torque_polarity_reflect = 1'b1;
        tick(2);
        chk("fwd swap", fwd_torque_limit_q, 32'h2bc);
        chk("rev swap", rev_torque_limit_q, 32'h1f4);
        travel_direction_select = 1'b0;
        $display("test clamp and swap done");
        droop_pulses = 32'hc8;
        ctrl.send_time(0, 16'h3);
        ctrl.send_time(2, 16'h2);
        for (i = 0; i < 9; i++) begin
            op_mode = stf_mode_e'(i);
            e = 16'h0;
            e[STF_SW_FOLLOWING_ERR_BIT] = op_mode inside {STF_MODE_CSP,
                STF_MODE_PP, STF_MODE_PT, STF_MODE_JG};
            e[STF_SW_TARGET_REACHED_BIT] = op_mode inside {STF_MODE_PP,
                STF_MODE_PT, STF_MODE_JG, STF_MODE_PV};
            wait_word(e, 40);
            tick(20);
            chk("mode status", status_word_q, e);
        end
        op_mode = STF_MODE_CSP;
        droop_pulses = 32'h0;
        tick(3);
        chk("fe cleared", status_word_q, 32'h0);
        droop_pulses = 32'hc8;
        tick(9);
        chk("fe early", status_word_q, 32'h0);
        wait_word(16'h2000, 30);
        following_err_level = STF_FE_LEVEL_DISABLED;
        droop_pulses = 32'hffffffff;
        tick(30);
        chk("fe disabled", status_word_q, 32'h0);
        op_mode = STF_MODE_PT;
        wr(STF_IDX_INP_TIME, 32'hea60);
        position_error = 32'hffffffff;
        tick(3);
        chk("inp out", status_word_q, 32'h0);
        in_position_range = STF_INP_RANGE_ALWAYS;
        wait_word(16'h0400, 4);
        $display("test filter timers done");
        fork
            ctrl.send_time(0, 16'h7);
            begin
                tick(1);
                wr(STF_IDX_FE_TIME, 32'h3);
            end
        join
        rd_chk(STF_IDX_FE_TIME, 32'h7);
        rd_chk(STF_IDX_SPD_TIME, 32'h2);
        wr(STF_IDX_SWITCH_SELECT, 32'h1);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        rd_chk(STF_IDX_SWITCH_SELECT, 32'h0);
        $display("test cyclic and reset done");
        stop_test();
    end
endmodule // stf_servo_limit_status_test
`default_nettype wire
